// ==== usb_ep0_pkg.sv ====
// Types shared by the EP0 status-stage responder
package usb_ep0_pkg;

  // Handshake chosen for one token
  typedef enum logic [1:0] {
    HS_NONE  = 2'h0,
    HS_ACK   = 2'h1,
    HS_NAK   = 2'h2,
    HS_STALL = 2'h3
  } handshake_e;

  // Token as delivered by the serial interface engine
  typedef struct packed {
    logic       is_in;
    logic       toggle;
    logic       crc_ok;
    logic [6:0] count;
  } token_s;

  // Responder sequencing
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } state_e;

endpackage : usb_ep0_pkg

// ==== usb_ep0_regs.svh ====
// Register indices, field positions, codes and limits of the EP0 responder
`ifndef USB_EP0_REGS_SVH
`define USB_EP0_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define EP0_CNT_IDX    8'h11
`define EP0_MODE_IDX   8'h12
`define INT_STAT_IDX   8'h20
`define INT_EN_IDX     8'h21
`define INT_CLR_IDX    8'h22

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MODE_SETUP_BIT 7
`define MODE_IN_BIT    6
`define MODE_OUT_BIT   5
`define MODE_ACK_BIT   4
`define CNT_TOG_BIT    7
`define CNT_VALID_BIT  6

// ----------------------------------------------------------------------
// Mode codes, limits and reset values
// ----------------------------------------------------------------------
`define MODE_ACK_IN    4'hf
`define MODE_NAK_IN    4'he
`define MODE_STAT_OUT  4'h2
`define MODE_STALL_ALL 4'h3
`define STATUS_LEN     7'h02
`define MAX_OUT_LEN    7'h0a
`define MODE_RST       8'h00
`define CNT_RST        8'h00

`endif

// ==== usb_ep0_status_stage_responder.sv ====
// EP0 status-stage responder with Wishbone registers and interrupt
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "usb_ep0_regs.svh"

module usb_ep0_status_stage_responder
  import usb_ep0_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Token from the serial engine
  input  wire logic        tok_valid_i,
  input  wire token_s      tok_i,
  output logic             tok_ready_o,
  // Handshake answer
  output logic             resp_valid_o,
  output handshake_e       resp_o,
  // Interrupt
  output logic             irq_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  state_e     state_reg;
  state_e     state_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       int_stat_reg;
  logic       int_stat_next;
  logic       int_en_reg;
  handshake_e resp_reg;
  logic       ack_reg;
  logic [31:0] rdata_reg;

  // Index decode shared by reads and writes
  function automatic logic is_idx(input logic [9:0] adr,
                                  input logic [7:0] idx);
    is_idx = (adr[9:2] == idx) && (adr[1:0] == 2'b00);
  endfunction : is_idx

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // Writes land on the edge where ack is high, as the master expects
  // Only the low byte is stored; a write with sel_i[0] low is dropped
  wire       wb_req   = cyc_i && stb_i;
  wire       wb_wr    = wb_req && we_i && ack_reg && sel_i[0];
  wire       sel_mode = is_idx(adr_i, `EP0_MODE_IDX);
  wire       sel_cnt  = is_idx(adr_i, `EP0_CNT_IDX);
  wire       sel_stat = is_idx(adr_i, `INT_STAT_IDX);
  wire       sel_en   = is_idx(adr_i, `INT_EN_IDX);
  wire       sel_clr  = is_idx(adr_i, `INT_CLR_IDX);
  wire       wr_mode  = wb_wr && sel_mode;
  wire       wr_en    = wb_wr && sel_en;
  wire       wr_clr   = wb_wr && sel_clr && dat_i[0];

  // Read mux; unmapped and write-only registers read as zero
  wire [31:0] rd_mux =
    sel_mode ? {24'h000000, mode_reg} :
    sel_cnt  ? {24'h000000, cnt_reg} :
    sel_stat ? {31'h00000000, int_stat_reg} :
    sel_en   ? {31'h00000000, int_en_reg} : 32'h00000000;

  // --------------------------------------------------------------------
  // Token classification
  // --------------------------------------------------------------------
  wire [3:0] mode_code = mode_reg[3:0];
  // One token in flight: the answer cycle blocks the next take
  wire tok_take  = tok_valid_i && (state_reg == ST_IDLE);
  wire st_mode   = (mode_code == `MODE_ACK_IN) ||
                   (mode_code == `MODE_NAK_IN) ||
                   (mode_code == `MODE_STAT_OUT);
  // Too long or corrupted data never reaches the registers
  wire out_bad   = (tok_i.count > `MAX_OUT_LEN) || !tok_i.crc_ok;
  wire out_two   = (tok_i.count == `STATUS_LEN);

  // Decision outputs
  handshake_e hs_dec;
  logic       set_in;
  logic       set_out;
  logic       set_ack;
  logic       upd_cnt;
  logic       chg_mode;
  logic [3:0] new_mode;
  logic       evt;

  // Decision table for the status-stage modes
  always_comb begin
    hs_dec   = HS_NONE;
    set_in   = 1'b0;
    set_out  = 1'b0;
    set_ack  = 1'b0;
    upd_cnt  = 1'b0;
    chg_mode = 1'b0;
    new_mode = mode_code;
    evt      = 1'b0;
    if (tok_take && st_mode) begin
      if (tok_i.is_in) begin
        set_in = 1'b1;
        evt    = 1'b1;
        unique case (mode_code)
          `MODE_ACK_IN: begin
            hs_dec   = HS_ACK;
            set_ack  = 1'b1;
            chg_mode = 1'b1;
            new_mode = `MODE_NAK_IN;
          end
          `MODE_NAK_IN: begin
            hs_dec = HS_NAK;
          end
          `MODE_STAT_OUT: begin
            hs_dec   = HS_STALL;
            chg_mode = 1'b1;
            new_mode = `MODE_STALL_ALL;
          end
        endcase
      // OUT tokens: only clean packets of ten bytes or less count
      end else if (!out_bad) begin
        set_out = 1'b1;
        upd_cnt = 1'b1;
        evt     = 1'b1;
        if (out_two && tok_i.toggle) begin
          hs_dec  = HS_ACK;
          set_ack = 1'b1;
        end else begin
          hs_dec   = HS_STALL;
          chg_mode = 1'b1;
          new_mode = `MODE_STALL_ALL;
        end
      end
      // Otherwise a long or corrupt OUT is dropped
    end
  end

  // --------------------------------------------------------------------
  // Next-state values
  // --------------------------------------------------------------------
  // Hardware flag sets and mode changes win over a software write
  wire [7:0] mode_sw  = wr_mode ? dat_i[7:0] : mode_reg;
  wire [7:0] flag_set = {1'b0, set_in, set_out, set_ack, 4'h0};
  assign mode_next = {mode_sw[7:4] | flag_set[7:4],
                      chg_mode ? new_mode : mode_sw[3:0]};
  // Byte count sits in the low nibble; long packets never get here
  assign cnt_next  = upd_cnt ?
                     {tok_i.toggle, 1'b1, 2'b00, tok_i.count[3:0]} :
                     cnt_reg;
  // Event set wins over a clear in the same cycle
  // so that no endpoint event is ever lost to a late clear
  assign int_stat_next = (int_stat_reg && !wr_clr) || evt;
  // Answer cycle always returns to idle; nothing waits there
  assign state_next    = tok_take ? ST_ANSWER : ST_IDLE;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Endpoint state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      mode_reg  <= `MODE_RST;
      cnt_reg   <= `CNT_RST;
      resp_reg  <= HS_NONE;
    end else if (ce_i) begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      cnt_reg   <= cnt_next;
      resp_reg  <= tok_take ? hs_dec : resp_reg;
    end
  end

  // Interrupt state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_reg <= 1'b0;
      int_en_reg   <= 1'b0;
    end else if (ce_i) begin
      int_stat_reg <= int_stat_next;
      int_en_reg   <= wr_en ? dat_i[0] : int_en_reg;
    end
  end

  // Bus answer: one wait cycle, ack dropped after one cycle
  // Enable low before ack stretches a bus cycle; a write whose ack edge falls while enable is low is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else if (ce_i) begin
      ack_reg   <= wb_req && !ack_reg;
      rdata_reg <= (wb_req && !ack_reg) ? rd_mux : rdata_reg;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Ready and answer-valid decode state; handshake code and data outputs come from flops
  // Irq is a level: high while an enabled status bit stands
  assign ack_o        = ack_reg;
  assign dat_o        = rdata_reg;
  assign tok_ready_o  = (state_reg == ST_IDLE);
  assign resp_valid_o = (state_reg == ST_ANSWER);
  assign resp_o       = resp_reg;
  assign irq_o        = int_stat_reg && int_en_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Token taken with no competing software write of the mode register
  wire hw_take = ce_i && tok_take && !wr_mode;

  in_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && tok_i.is_in && mode_code == `MODE_ACK_IN |=>
      resp_valid_o && resp_o == HS_ACK && mode_reg[`MODE_IN_BIT] &&
      mode_reg[`MODE_ACK_BIT] && int_stat_reg &&
      mode_reg[3:0] == `MODE_NAK_IN)
    else $error("IN in ACK-IN mode not acknowledged");

  out_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !tok_i.is_in && st_mode && !out_bad && out_two &&
      tok_i.toggle |=>
      resp_o == HS_ACK && cnt_reg[`CNT_TOG_BIT] &&
      mode_reg[`MODE_OUT_BIT] && mode_reg[`MODE_ACK_BIT] &&
      mode_reg[3:0] == $past(mode_reg[3:0]))
    else $error("Good status OUT not acknowledged");

  tog_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !tok_i.is_in && st_mode && !out_bad && out_two &&
      !tok_i.toggle |=>
      resp_o == HS_STALL && !cnt_reg[`CNT_TOG_BIT] &&
      mode_reg[3:0] == `MODE_STALL_ALL && int_stat_reg)
    else $error("Toggle-zero status OUT not stalled");

  len_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !tok_i.is_in && st_mode && !out_bad && !out_two |=>
      resp_o == HS_STALL && mode_reg[3:0] == `MODE_STALL_ALL &&
      !mode_reg[`MODE_ACK_BIT] == !$past(mode_reg[`MODE_ACK_BIT]))
    else $error("Wrong-length status OUT not stalled");

  bad_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !tok_i.is_in && out_bad && !wb_wr |=>
      resp_o == HS_NONE && cnt_reg == $past(cnt_reg) &&
      mode_reg == $past(mode_reg) &&
      int_stat_reg == $past(int_stat_reg))
    else $error("Bad OUT changed state or was answered");

  in_nak_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && tok_i.is_in && mode_code == `MODE_NAK_IN |=>
      resp_o == HS_NAK && mode_reg[`MODE_IN_BIT] &&
      mode_reg[3:0] == `MODE_NAK_IN &&
      mode_reg[`MODE_ACK_BIT] == $past(mode_reg[`MODE_ACK_BIT]))
    else $error("IN in NAK-IN mode not refused");

  in_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && tok_i.is_in && mode_code == `MODE_STAT_OUT |=>
      resp_o == HS_STALL && mode_reg[`MODE_IN_BIT] &&
      mode_reg[3:0] == `MODE_STALL_ALL)
    else $error("IN in status-OUT mode not stalled");

  mode_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ack_o) && !we_i && sel_mode |->
      dat_o == {24'h000000, $past(mode_reg)})
    else $error("Mode register read mismatch");

  cnt_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !tok_i.is_in && st_mode && !out_bad |=>
      cnt_reg[3:0] == $past(tok_i.count[3:0]) &&
      cnt_reg[`CNT_VALID_BIT] && cnt_reg[5:4] == 2'b00)
    else $error("Counter register fields wrong");

  answer_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tok_take |=> resp_valid_o && !tok_ready_o)
    else $error("Token answer not presented");

  // One answer per token: the answer pulse lasts a single cycle
  answer_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && resp_valid_o |=> !resp_valid_o && tok_ready_o)
    else $error("Token answer stood for more than one cycle");

  // Bus answer is a one-cycle pulse while the clock runs
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ack_o |=> !ack_o)
    else $error("Bus ack held for more than one cycle");

  // Enable low must freeze mode, counter, state and status registers, bus ack included
  freeze_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(mode_reg) && $stable(cnt_reg) &&
      $stable(state_reg) && $stable(ack_o) && $stable(int_stat_reg))
    else $error("State moved while the clock enable was low");

  // A counted token sets status even against a clear in that cycle
  int_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tok_take && st_mode && (tok_i.is_in || !out_bad) |=>
      int_stat_reg)
    else $error("Token event did not set the interrupt status");

  // Tokens outside the status-stage modes get no handshake
  other_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !st_mode |=>
      resp_o == HS_NONE && mode_reg == $past(mode_reg) &&
      cnt_reg == $past(cnt_reg))
    else $error("Token outside status modes was answered");

  // Counter register reads back what the last token left
  cnt_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ack_o) && !we_i && sel_cnt |->
      dat_o == {24'h000000, $past(cnt_reg)})
    else $error("Counter register read mismatch");

  // Main scenarios worth seeing at least once

  cov_ack_in_c:  cover property (@(posedge clk_i) disable iff (rst_i)
    hw_take && tok_i.is_in && mode_code == `MODE_ACK_IN);
  cov_out_ack_c: cover property (@(posedge clk_i) disable iff (rst_i)
    hw_take && !tok_i.is_in && !out_bad && out_two && tok_i.toggle);
  cov_stall_c:   cover property (@(posedge clk_i) disable iff (rst_i)
    hw_take && chg_mode && new_mode == `MODE_STALL_ALL);
  cov_irq_c:     cover property (@(posedge clk_i) disable iff (rst_i)
    irq_o ##1 !irq_o);
  cov_freeze_c:  cover property (@(posedge clk_i) disable iff (rst_i)
    !ce_i && tok_valid_i);

endmodule : usb_ep0_status_stage_responder

// ==== usb_ep0_status_stage_responder_tb.sv ====
// Self-checking bench for the EP0 status-stage responder
`timescale 1ns/10ps
`include "usb_ep0_regs.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module usb_ep0_status_stage_responder_tb
  import usb_ep0_pkg::*;
;
  // ------------------------------------------------------------------
  // Clock, reset and wiring
  // ------------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0, dat_o;
  logic        ack, tok_valid, tok_ready, resp_valid, irq, ien;
  logic        ce = 1'b1;
  token_s      tok;
  handshake_e  resp;
  int          n_mismatch = 0, total_checks = 0;

  usb_ep0_status_stage_responder dut_u (.clk_i(clk), .rst_i(rst),
    .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .tok_valid_i(tok_valid), .tok_i(tok), .tok_ready_o(tok_ready),
    .resp_valid_o(resp_valid), .resp_o(resp), .irq_o(irq));

  usb_host_model host_u (.clk_i(clk), .tok_ready_i(tok_ready),
    .resp_valid_i(resp_valid), .resp_i(resp), .tok_valid_o(tok_valid),
    .tok_o(tok));

  initial begin
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    sel <= 4'hf;
    // No wait count assumed; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb

  function automatic token_s tk(logic i, logic tg, logic ok, logic [6:0] c);
    return '{is_in: i, toggle: tg, crc_ok: ok, count: c};
  endfunction : tk

  // Clear status, set mode, send one token, then check every effect
  task automatic run(input logic [7:0] md, input token_s t,
                     input handshake_e ehs, input logic [7:0] emd,
                     input logic [7:0] ecn, input logic est);
    handshake_e hs;
    logic [31:0] q;
    wb(1'b1, `INT_CLR_IDX, 32'h1, q);
    wb(1'b1, `EP0_MODE_IDX, {24'h0, md}, q);
    host_u.issue(t, 0, hs);
    `CHK("handshake", ehs, hs)
    wb(1'b0, `EP0_MODE_IDX, 32'h0, q);
    `CHK("mode", {24'h0, emd}, q)
    wb(1'b0, `EP0_CNT_IDX, 32'h0, q);
    `CHK("counter", {24'h0, ecn}, q)
    wb(1'b0, `INT_STAT_IDX, 32'h0, q);
    `CHK("status", {31'h0, est}, q)
    `CHK("irq", est & ien, irq)
  endtask : run

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    wb(1'b1, `EP0_CNT_IDX, 32'hff, q);
    wb(1'b0, `EP0_CNT_IDX, 32'h0, q);
    `CHK("cnt_rst", 32'h0, q)
    wb(1'b0, `EP0_MODE_IDX, 32'h0, q);
    `CHK("mode_rst", 32'h0, q)
    wb(1'b0, 8'h30, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, `INT_EN_IDX, 32'h1, q);
    ien = 1'b1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_in_modes();
    handshake_e hs;
    run(8'h0f, tk(1, 0, 1, 0), HS_ACK, 8'h5e, 8'h00, 1);
    run(8'h0e, tk(1, 0, 1, 0), HS_NAK, 8'h4e, 8'h00, 1);
    host_u.issue(tk(1, 0, 1, 0), 0, hs);
    `CHK("nak_again", HS_NAK, hs)
    run(8'h02, tk(1, 0, 1, 0), HS_STALL, 8'h43, 8'h00, 1);
    $display("test in tokens done");
  endtask : t_in_modes

  task automatic t_out_modes();
    run(8'h0e, tk(0, 1, 1, 2), HS_ACK, 8'h3e, 8'hc2, 1);
    run(8'h0f, tk(0, 0, 1, 2), HS_STALL, 8'h23, 8'h42, 1);
    run(8'h02, tk(0, 1, 1, 10), HS_STALL, 8'h23, 8'hca, 1);
    $display("test out tokens done");
  endtask : t_out_modes

  task automatic t_ignore_mask();
    logic [31:0] q;
    run(8'h0f, tk(0, 1, 1, 11), HS_NONE, 8'h0f, 8'hca, 0);
    run(8'h0e, tk(0, 1, 0, 2), HS_NONE, 8'h0e, 8'hca, 0);
    run(8'h03, tk(1, 0, 1, 0), HS_NONE, 8'h03, 8'hca, 0);
    wb(1'b1, `INT_EN_IDX, 32'h0, q);
    ien = 1'b0;
    run(8'h0e, tk(1, 0, 1, 0), HS_NAK, 8'h4e, 8'hca, 1);
    $display("test ignore and mask done");
  endtask : t_ignore_mask

  // Enable low: a token offered then must leave no trace
  task automatic t_freeze();
    handshake_e hs;
    logic [31:0] q;
    wb(1'b1, `INT_CLR_IDX, 32'h1, q);
    wb(1'b1, `EP0_MODE_IDX, 32'h0e, q);
    ce <= 1'b0;
    host_u.issue(tk(1, 0, 1, 0), 0, hs);
    `CHK("frozen_valid", 1'b0, resp_valid)
    ce <= 1'b1;
    wb(1'b0, `EP0_MODE_IDX, 32'h0, q);
    `CHK("frozen_mode", 32'h0e, q)
    wb(1'b0, `INT_STAT_IDX, 32'h0, q);
    `CHK("frozen_stat", 32'h0, q)
    $display("test clock enable done");
  endtask : t_freeze

  // ------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    ien = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_in_modes();
    t_out_modes();
    t_ignore_mask();
    t_freeze();
    print_verdict();
  end
endmodule : usb_ep0_status_stage_responder_tb

// ==== usb_host_model.sv ====
// Host-side model that issues tokens and collects the handshakes
`timescale 1ns/10ps

module usb_host_model
  import usb_ep0_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Answer from the responder
  input  wire logic       tok_ready_i,
  input  wire logic       resp_valid_i,
  input  wire handshake_e resp_i,
  // Token to the responder
  output logic            tok_valid_o,
  output token_s          tok_o
);
  // ------------------------------------------------------------------
  // Token issue
  // ------------------------------------------------------------------
  initial begin
    tok_valid_o = 1'b0;
    tok_o       = '0;
  end

  // Hold until taken; released lines show the inverse, not a stale copy
  task automatic issue(input token_s t, input int gap,
                       output handshake_e hs);
    repeat (gap) @(posedge clk_i);
    tok_valid_o <= 1'b1;
    tok_o       <= t;
    // Only the bench watchdog ends a wait that never sees ready
    do begin
      @(posedge clk_i);
    end while (tok_ready_i !== 1'b1);
    tok_valid_o <= 1'b0;
    tok_o       <= ~t;
    @(posedge clk_i);
    // No answer pulse reads as unknown so it never passes a compare
    hs = (resp_valid_i === 1'b1) ? resp_i : handshake_e'(2'bxx);
  endtask : issue
endmodule : usb_host_model
